// ---- src/dpsc_regs.vh ----
// constants for the slave state control block: command bits, state codes, rate codes
// assumes plain verilog-2005 inclusion by bare name
`ifndef DPSC_REGS_VH
`define DPSC_REGS_VH
// ------------------------------------------------------------
// control command byte bit positions
// ------------------------------------------------------------
`define DPSC_GC_CLEAR 1
`define DPSC_GC_UNFREEZE 2
`define DPSC_GC_FREEZE 3
`define DPSC_GC_UNSYNC 4
`define DPSC_GC_SYNC 5
// ------------------------------------------------------------
// slave state encodings
// ------------------------------------------------------------
`define DPSC_ST_AWAIT_PARAMS 2'h0
`define DPSC_ST_AWAIT_CONFIG 2'h1
`define DPSC_ST_EXCHANGING 2'h2
`define DPSC_ST_FAULT 2'h3
// ------------------------------------------------------------
// watchdog state encodings
// ------------------------------------------------------------
`define DPSC_WD_RATE_SEARCH 2'h0
`define DPSC_WD_RATE_CHECK 2'h1
`define DPSC_WD_BUS_MONITORING 2'h2
// ------------------------------------------------------------
// baud rate codes, ram limit and reset command byte
// ------------------------------------------------------------
`define DPSC_BD_12M 4'h0
`define DPSC_BD_9_6K 4'h8
`define DPSC_BD_NONE 4'hF
`define DPSC_RAM_LIMIT 11'h600
`define DPSC_RESET_GC 8'h00
`endif

// ---- src/dpsc_sync2.v ----
// two-flop synchroniser for asynchronous pins
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
module dpsc_sync2 (
    input wire clk, // system clock
    input wire rst, // async reset
    input wire ce, // clock enable
    input wire d, // asynchronous level
    output reg q // synchronised level
);
    reg meta_q;
    // ------------------------------------------------------------
    // two stages; first stage feeds only the second
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ---- src/dpsc_ram_guard.v ----
// ram range checker: flags accesses at or above the ram limit
// assumes address and strobe come from logic on clk
`timescale 1ns/1ps
`include "dpsc_regs.vh"
module dpsc_ram_guard (
    input wire clk, // system clock
    input wire rst, // async reset
    input wire ce, // clock enable
    input wire acc_stb, // one-cycle access strobe
    input wire [10:0] acc_addr, // byte address of access
    input wire acc_host, // access made by host processor
    input wire host_bus_variant_a, // variant where host errors are silent
    input wire clr, // re-initialisation clears the fault
    output reg ram_range_fault, // sticky fault status
    output reg link_layer_halt, // halt indication
    output reg fault_event // one-cycle fault message
);
    wire bad;
    // out of range: beyond the 1.5 kb array
    assign bad = acc_stb && (acc_addr >= `DPSC_RAM_LIMIT); // RQ16
    // ------------------------------------------------------------
    // sticky fault; a new error wins over the clear
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_range_fault <= 1'b0;
            link_layer_halt <= 1'b0;
            fault_event <= 1'b0;
        end else if (ce) begin
            if (bad) begin
                ram_range_fault <= 1'b1; // RQ16
                link_layer_halt <= 1'b1; // RQ16
            end else if (clr) begin
                ram_range_fault <= 1'b0;
                link_layer_halt <= 1'b0;
            end
            // host errors stay silent in variant a, sequencer errors never do
            fault_event <= bad && !(acc_host && host_bus_variant_a); // RQ17
        end
    end
endmodule

// ---- src/dpsc_state_ctrl.v ----
// slave state control: global control decode, slave and watchdog states
// assumes master-side telegram strobes come from logic on clk; host requests
// and the variant strap are pins and are synchronised here
`timescale 1ns/1ps
`include "dpsc_regs.vh"
// What this block does
// RQ1: global-control event only on own group and a changed command byte
// RQ2: clear bit erases outputs, hands erased buffer to the user
// RQ3: unfreeze bit cancels active input freezing
// RQ4: freeze bit latches input data until the next freeze command; re-latched only when the command byte changes
// RQ5: sync shows latest outputs and holds later ones; unsync cancels
// RQ6: bits 0, 6 and 7 are reserved and do nothing
// RQ7: data-exchange-left event on any entry into or exit from exchange
// RQ8: slave state reported as params, config, exchange or fault
// RQ9: faulty parameter telegram during exchange leaves exchange
// RQ10: go-offline enters offline; only re-initialisation leaves it
// RQ11: passive idle status reads 1, offline reads 0
// RQ12: bus-monitor-expired event when response monitoring runs out
// RQ13: watchdog state reported as rate search, rate check or bus monitoring
// RQ14: leave-master request returns slave to awaiting parameters
// RQ15: detected baud rate reported as one of nine codes
// RQ16: access beyond 1.5 kb ram raises halt and range fault
// RQ17: variant a host errors silent; sequencer errors still flagged
// RQ18: watchdog goes rate search, then rate check, then bus monitoring
module dpsc_state_ctrl (
    input wire clk, // 125 mhz clock
    input wire rst, // async reset, active high
    input wire ce, // clock enable, freezes all state
    input wire gc_stb, // global control telegram received
    input wire gc_group_hit, // telegram addresses our group
    input wire [7:0] gc_cmd, // control command byte
    input wire prm_ok_stb, // good parameter telegram
    input wire prm_bad_stb, // faulty parameter telegram
    input wire cfg_ok_stb, // good configuration telegram
    input wire cfg_bad_stb, // faulty configuration telegram
    input wire out_stb, // new output data received
    input wire [7:0] out_data, // received output byte
    input wire [7:0] in_data, // application input byte
    input wire rate_found_stb, // baud search locked on a rate
    input wire [3:0] rate_code, // code of the rate found
    input wire rate_lost_stb, // rate check failed
    input wire rate_ok_stb, // rate check passed, telegram for us
    input wire monitor_expired_stb, // response monitor ran out
    input wire acc_stb, // internal ram access strobe
    input wire [10:0] acc_addr, // internal ram byte address
    input wire acc_host, // access made by host
    input wire go_offline_request, // host pin: go offline
    input wire reinit_request, // host pin: full re-initialisation
    input wire leave_master_request, // host pin: force reparameterisation
    input wire host_bus_variant_a, // strap pin
    output reg gc_event, // new global control command, pulse
    output reg [7:0] gc_cmd_q, // last accepted command byte
    output reg [7:0] app_out_q, // output data seen by application
    output reg [7:0] bus_in_q, // input data sent to master
    output reg user_buf_owned_q, // erased buffer owned by user
    output reg data_exchange_left_event, // exchange entered or left, pulse
    output reg [1:0] slave_state_q, // slave state code
    output reg passive_idle_q, // 1 passive idle, 0 offline
    output reg bus_monitor_expired_event, // monitor ran out, pulse
    output reg [1:0] wdog_state_q, // watchdog state code
    output reg [3:0] baud_code_q, // detected baud rate
    output wire ram_range_fault, // sticky addressing error
    output wire link_layer_halt, // halt on addressing error
    output wire ram_fault_event // addressing error message, pulse
);
    wire off_s;
    wire reinit_s;
    wire leave_s;
    wire variant_s;
    reg off_d1_q;
    reg reinit_d1_q;
    reg leave_d1_q;
    reg freeze_q;
    reg sync_q;
    reg [7:0] last_out_q;
    reg [1:0] slave_state_d;
    reg [1:0] wdog_state_d;
    wire off_rise;
    wire reinit_rise;
    wire leave_rise;
    wire gc_take;
    wire [3:0] pin_vec;
    wire [3:0] pin_sync;

    assign pin_vec = {host_bus_variant_a, leave_master_request, reinit_request, go_offline_request};
    // ------------------------------------------------------------
    // pin synchronisers, one per host pin and one for the variant strap
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            dpsc_sync2 u_sync (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .d(pin_vec[gi]),
                .q(pin_sync[gi])
            );
        end
    endgenerate
    assign off_s = pin_sync[0];
    assign reinit_s = pin_sync[1];
    assign leave_s = pin_sync[2];
    assign variant_s = pin_sync[3];

    // requests act once per rising edge of the synchronised level
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            off_d1_q <= 1'b0;
            reinit_d1_q <= 1'b0;
            leave_d1_q <= 1'b0;
        end else if (ce) begin
            off_d1_q <= off_s;
            reinit_d1_q <= reinit_s;
            leave_d1_q <= leave_s;
        end
    end
    assign off_rise = off_s && !off_d1_q;
    assign reinit_rise = reinit_s && !reinit_d1_q;
    assign leave_rise = leave_s && !leave_d1_q;

    // ------------------------------------------------------------
    // global control decode
    // ------------------------------------------------------------
    // repeated identical commands are ignored, so freeze only re-latches when
    // the master toggles the byte; a limitation the master knows about
    assign gc_take = gc_stb && gc_group_hit && (gc_cmd != gc_cmd_q) && passive_idle_q; // RQ1

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gc_event <= 1'b0;
            gc_cmd_q <= `DPSC_RESET_GC;
            freeze_q <= 1'b0;
            sync_q <= 1'b0;
            last_out_q <= 8'h00;
            app_out_q <= 8'h00;
            bus_in_q <= 8'h00;
            user_buf_owned_q <= 1'b0;
        end else if (ce) begin
            gc_event <= gc_take; // RQ1
            if (out_stb) last_out_q <= out_data;
            if (gc_take) begin
                gc_cmd_q <= gc_cmd; // RQ1
            end
            // reserved bits 0, 6, 7 are stored but decode nothing
            if (gc_take && gc_cmd[`DPSC_GC_UNFREEZE]) begin // RQ6
                freeze_q <= 1'b0; // RQ3
            end else if (gc_take && gc_cmd[`DPSC_GC_FREEZE]) begin
                freeze_q <= 1'b1; // RQ4
            end
            if (gc_take && gc_cmd[`DPSC_GC_UNSYNC]) begin
                sync_q <= 1'b0; // RQ5
            end else if (gc_take && gc_cmd[`DPSC_GC_SYNC]) begin
                sync_q <= 1'b1; // RQ5
            end
            // input path: frozen copy re-latched only on a freeze command
            if (gc_take && gc_cmd[`DPSC_GC_FREEZE]) begin
                bus_in_q <= in_data; // RQ4
            end else if (!freeze_q) begin
                bus_in_q <= in_data;
            end
            // output path: clear beats sync, sync beats live update
            if (gc_take && gc_cmd[`DPSC_GC_CLEAR]) begin
                app_out_q <= 8'h00; // RQ2
                user_buf_owned_q <= 1'b1; // RQ2
            end else if (gc_take && gc_cmd[`DPSC_GC_SYNC] && !gc_cmd[`DPSC_GC_UNSYNC]) begin
                app_out_q <= last_out_q; // RQ5
            end else if (out_stb && !sync_q) begin
                app_out_q <= out_data;
                user_buf_owned_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // slave state machine
    // ------------------------------------------------------------
    always @* begin
        slave_state_d = slave_state_q;
        case (slave_state_q)
            `DPSC_ST_AWAIT_PARAMS: begin
                if (prm_ok_stb) begin
                    slave_state_d = `DPSC_ST_AWAIT_CONFIG;
                end else if (prm_bad_stb) begin
                    slave_state_d = `DPSC_ST_FAULT;
                end
            end
            `DPSC_ST_AWAIT_CONFIG: begin
                if (cfg_ok_stb) begin
                    slave_state_d = `DPSC_ST_EXCHANGING;
                end else if (cfg_bad_stb || prm_bad_stb) begin
                    slave_state_d = `DPSC_ST_FAULT;
                end
            end
            `DPSC_ST_EXCHANGING: begin
                if (prm_bad_stb || cfg_bad_stb) begin
                    slave_state_d = `DPSC_ST_AWAIT_PARAMS; // RQ9
                end
            end
            `DPSC_ST_FAULT: begin
                if (prm_ok_stb) begin
                    slave_state_d = `DPSC_ST_AWAIT_CONFIG;
                end
            end
            default: begin
                slave_state_d = `DPSC_ST_AWAIT_PARAMS;
            end
        endcase
        // host requests override the bus telegrams
        if (leave_rise || !passive_idle_q) begin
            slave_state_d = `DPSC_ST_AWAIT_PARAMS; // RQ14
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slave_state_q <= `DPSC_ST_AWAIT_PARAMS;
            data_exchange_left_event <= 1'b0;
        end else if (ce) begin
            slave_state_q <= slave_state_d; // RQ8
            // any crossing of the exchange boundary, either way
            data_exchange_left_event <= (slave_state_q == `DPSC_ST_EXCHANGING) !=
                                        (slave_state_d == `DPSC_ST_EXCHANGING); // RQ7
        end
    end

    // ------------------------------------------------------------
    // offline / passive idle
    // ------------------------------------------------------------
    // starts passive idle; offline is sticky until a re-initialisation
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            passive_idle_q <= 1'b1; // RQ11
        end else if (ce) begin
            if (off_rise) begin
                passive_idle_q <= 1'b0; // RQ10
            end else if (reinit_rise) begin
                passive_idle_q <= 1'b1; // RQ10
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog state machine and baud rate
    // ------------------------------------------------------------
    always @* begin
        wdog_state_d = wdog_state_q;
        case (wdog_state_q)
            `DPSC_WD_RATE_SEARCH: begin
                if (rate_found_stb && rate_code <= `DPSC_BD_9_6K) begin
                    wdog_state_d = `DPSC_WD_RATE_CHECK; // RQ18
                end
            end
            `DPSC_WD_RATE_CHECK: begin
                if (rate_lost_stb) begin
                    wdog_state_d = `DPSC_WD_RATE_SEARCH;
                end else if (rate_ok_stb) begin
                    wdog_state_d = `DPSC_WD_BUS_MONITORING; // RQ18
                end
            end
            `DPSC_WD_BUS_MONITORING: begin
                if (monitor_expired_stb) begin
                    wdog_state_d = `DPSC_WD_RATE_SEARCH;
                end
            end
            default: begin
                wdog_state_d = `DPSC_WD_RATE_SEARCH;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wdog_state_q <= `DPSC_WD_RATE_SEARCH;
            baud_code_q <= `DPSC_BD_NONE;
            bus_monitor_expired_event <= 1'b0;
        end else if (ce) begin
            wdog_state_q <= wdog_state_d; // RQ13
            // expiry only counts while monitoring is active
            bus_monitor_expired_event <= monitor_expired_stb &&
                                         (wdog_state_q == `DPSC_WD_BUS_MONITORING); // RQ12
            if (wdog_state_q == `DPSC_WD_RATE_SEARCH && rate_found_stb && rate_code <= `DPSC_BD_9_6K) begin
                baud_code_q <= rate_code; // RQ15
            end
        end
    end

    // ------------------------------------------------------------
    // ram range checker
    // ------------------------------------------------------------
    dpsc_ram_guard u_guard (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .acc_stb(acc_stb),
        .acc_addr(acc_addr),
        .acc_host(acc_host),
        .host_bus_variant_a(variant_s),
        .clr(reinit_rise),
        .ram_range_fault(ram_range_fault),
        .link_layer_halt(link_layer_halt),
        .fault_event(ram_fault_event)
    );
endmodule

// ---- tb/dpsc_state_chk.sv ----
// checker for the slave state control block, bound onto its top module
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module dpsc_state_chk (
    input wire clk, // clock
    input wire rst, // reset
    input wire ce, // enable
    input wire gc_stb, // gc strobe
    input wire gc_group_hit, // group match
    input wire [7:0] gc_cmd, // command byte
    input wire prm_bad_stb, // bad param
    input wire monitor_expired_stb, // monitor ran out
    input wire acc_stb, // ram access
    input wire [10:0] acc_addr, // ram address
    input wire acc_host, // host access
    input wire gc_event, // gc pulse
    input wire [7:0] gc_cmd_q, // last command
    input wire data_exchange_left_event, // exchange pulse
    input wire [1:0] slave_state_q, // slave state
    input wire passive_idle_q, // idle status
    input wire bus_monitor_expired_event, // monitor pulse
    input wire [1:0] wdog_state_q, // watchdog state
    input wire [3:0] baud_code_q, // rate code
    input wire ram_range_fault, // range fault
    input wire link_layer_halt, // halt
    input wire ram_fault_event // fault pulse
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_gc_event_cause: assert property (gc_event |->
        $past(ce && gc_stb && gc_group_hit && gc_cmd != gc_cmd_q && passive_idle_q)) else $error("gc event uncaused");
    chk_gc_repeat_quiet: assert property (ce && gc_stb && gc_cmd == gc_cmd_q |=> !gc_event)
        else $error("repeated command flagged");
    chk_gc_cmd_load: assert property (gc_event |-> gc_cmd_q == $past(gc_cmd))
        else $error("command byte not stored");
    // the pulse must mark exactly the edges where exchange is entered or left
    chk_dx_event_match: assert property (data_exchange_left_event ==
        (($past(slave_state_q) == 2'h2) != (slave_state_q == 2'h2))) else $error("exchange event mismatch");
    chk_bad_prm_exit: assert property (ce && prm_bad_stb && slave_state_q == 2'h2 |=>
        slave_state_q != 2'h2 && data_exchange_left_event) else $error("bad param kept exchange");
    chk_wdog_code_legal: assert property (wdog_state_q != 2'h3) else $error("bad watchdog code");
    chk_monitor_event_cause: assert property (bus_monitor_expired_event |->
        $past(monitor_expired_stb && wdog_state_q == 2'h2)) else $error("monitor event uncaused");
    chk_baud_code_legal: assert property (baud_code_q <= 4'h8 || baud_code_q == 4'hF)
        else $error("bad rate code");
    chk_ram_fault_raise: assert property (ce && acc_stb && !acc_host && acc_addr >= 11'h600 |=>
        ram_range_fault && link_layer_halt && ram_fault_event) else $error("range fault missed");
    chk_ram_fault_cause: assert property (ram_fault_event |-> $past(acc_stb && acc_addr >= 11'h600))
        else $error("range fault uncaused");
endmodule

// ---- tb/dpsc_master_model.sv ----
// bus master model: issues telegram strobes to the slave state control
// assumes the caller is in a process clocked by clk
`timescale 1ns/1ps
module dpsc_master_model (
    input wire clk, // clock
    output reg gc_stb, // gc telegram
    output reg gc_group_hit, // group match
    output reg [7:0] gc_cmd, // command byte
    output reg prm_ok_stb, // good param
    output reg prm_bad_stb, // bad param
    output reg cfg_ok_stb, // good config
    output reg cfg_bad_stb, // bad config
    output reg out_stb, // output data
    output reg [7:0] out_data, // output byte
    output reg rate_found_stb, // rate found
    output reg [3:0] rate_code, // rate code
    output reg rate_lost_stb, // rate lost
    output reg rate_ok_stb, // rate ok
    output reg monitor_expired_stb // monitor ran out
);
    // ------------------------------------------------------------
    // telegram task: k selects kind, 10 is a gc for another group
    // ------------------------------------------------------------
    initial begin
        {gc_stb, gc_group_hit, gc_cmd, prm_ok_stb, prm_bad_stb, cfg_ok_stb, cfg_bad_stb} = 0;
        {out_stb, out_data, rate_found_stb, rate_code, rate_lost_stb, rate_ok_stb, monitor_expired_stb} = 0;
    end
    task send(input [3:0] k, input [7:0] b);
        begin
            @(posedge clk);
            gc_stb <= k == 4'h0 || k == 4'hA;
            gc_group_hit <= k == 4'h0;
            {gc_cmd, out_data, rate_code} <= {b, b, b[3:0]};
            {prm_ok_stb, prm_bad_stb, cfg_ok_stb, cfg_bad_stb} <= {k == 4'h1, k == 4'h2, k == 4'h3, k == 4'h4};
            {out_stb, rate_found_stb, rate_lost_stb} <= {k == 4'h5, k == 4'h6, k == 4'h7};
            {rate_ok_stb, monitor_expired_stb} <= {k == 4'h8, k == 4'h9};
            @(posedge clk);
            // inverted junk between frames, so nothing stale looks valid
            {gc_stb, gc_group_hit, prm_ok_stb, prm_bad_stb, cfg_ok_stb, cfg_bad_stb, out_stb} <= 0;
            {rate_found_stb, rate_lost_stb, rate_ok_stb, monitor_expired_stb} <= 0;
            {gc_cmd, out_data, rate_code} <= {~b, ~b, ~b[3:0]};
        end
    endtask
endmodule

// ---- tb/test_dpsc_state_ctrl.sv ----
// self-checking bench for the slave state control block
// assumes the master model and checker files are compiled first
`timescale 1ns/1ps
module test_dpsc_state_ctrl;
    reg clk, rst, ce, acc_stb, acc_host, go_offline_request, reinit_request, leave_master_request;
    reg host_bus_variant_a;
    reg [7:0] in_data;
    reg [10:0] acc_addr;
    wire gc_stb, gc_group_hit, prm_ok_stb, prm_bad_stb, cfg_ok_stb, cfg_bad_stb, out_stb;
    wire rate_found_stb, rate_lost_stb, rate_ok_stb, monitor_expired_stb;
    wire [7:0] gc_cmd, out_data, gc_cmd_q, app_out_q, bus_in_q;
    wire [3:0] rate_code, baud_code_q;
    wire [1:0] slave_state_q, wdog_state_q;
    wire gc_event, user_buf_owned_q, data_exchange_left_event, passive_idle_q, bus_monitor_expired_event;
    wire ram_range_fault, link_layer_halt, ram_fault_event;
    integer fails, checked, i;
    dpsc_master_model m (.clk, .gc_stb, .gc_group_hit, .gc_cmd, .prm_ok_stb, .prm_bad_stb, .cfg_ok_stb,
        .cfg_bad_stb, .out_stb, .out_data, .rate_found_stb, .rate_code, .rate_lost_stb, .rate_ok_stb,
        .monitor_expired_stb);
    dpsc_state_ctrl uut (.clk, .rst, .ce, .gc_stb, .gc_group_hit, .gc_cmd, .prm_ok_stb, .prm_bad_stb,
        .cfg_ok_stb, .cfg_bad_stb, .out_stb, .out_data, .in_data, .rate_found_stb, .rate_code,
        .rate_lost_stb, .rate_ok_stb, .monitor_expired_stb, .acc_stb, .acc_addr, .acc_host,
        .go_offline_request, .reinit_request, .leave_master_request, .host_bus_variant_a, .gc_event,
        .gc_cmd_q, .app_out_q, .bus_in_q, .user_buf_owned_q, .data_exchange_left_event, .slave_state_q,
        .passive_idle_q, .bus_monitor_expired_event, .wdog_state_q, .baud_code_q, .ram_range_fault,
        .link_layer_halt, .ram_fault_event);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task tl(input [3:0] k, input [7:0] b);
        begin
            m.send(k, b);
            #1;
        end
    endtask
    // pins pass a synchroniser; hold well past its two-edge latency
    task pin(input integer k);
        begin
            @(posedge clk);
            {go_offline_request, reinit_request, leave_master_request} <= 3'h4 >> k;
            repeat (5) @(posedge clk);
            {go_offline_request, reinit_request, leave_master_request} <= 3'h0;
            repeat (5) @(posedge clk);
            #1;
        end
    endtask
    task acc(input [10:0] a, input h);
        begin
            @(posedge clk);
            {acc_stb, acc_addr, acc_host} <= {1'b1, a, h};
            @(posedge clk);
            {acc_stb, acc_addr} <= {1'b0, ~a};
            #1;
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checked, fails);
            if (fails == 0 && checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #400000;
        fails = fails + 1;
        tally_and_finish;
    end
    initial begin
        {rst, ce, acc_stb, acc_host, go_offline_request, reinit_request, leave_master_request} = 7'h60;
        {host_bus_variant_a, acc_addr, fails, checked} = 0;
        in_data = 8'hA5;
        repeat (5) @(posedge clk);
        rst <= 0;
        #1;
        chk("reset", {passive_idle_q, slave_state_q, wdog_state_q, baud_code_q, ram_range_fault}, 10'h21E);
        $display("test reset done");
        tl(0, 8'h08);
        chk("freeze", {gc_event, bus_in_q}, 9'h1A5);
        @(posedge clk) in_data <= 8'h3C;
        tl(0, 8'h08);
        chk("repeat", {gc_event, bus_in_q}, 9'h0A5);
        tl(10, 8'h04);
        chk("group", gc_event, 0);
        tl(0, 8'h04);
        chk("unfreeze", {gc_event, gc_cmd_q}, 9'h104);
        tl(0, 8'h08);
        chk("refreeze", bus_in_q, 8'h3C);
        tl(5, 8'h11);
        tl(0, 8'h20);
        chk("sync", app_out_q, 8'h11);
        tl(5, 8'h22);
        chk("sync_hold", app_out_q, 8'h11);
        tl(0, 8'h10);
        tl(0, 8'h20);
        chk("resync", app_out_q, 8'h22);
        tl(0, 8'hC1);
        chk("reserved", {gc_event, gc_cmd_q, app_out_q, bus_in_q, user_buf_owned_q}, 26'h3824478);
        tl(0, 8'h02);
        chk("clear", {user_buf_owned_q, app_out_q}, 9'h100);
        $display("test control done");
        tl(1, 0);
        chk("params", slave_state_q, 1);
        tl(3, 0);
        chk("enter", {slave_state_q, data_exchange_left_event}, 3'h5);
        tl(2, 0);
        chk("bad_prm", {slave_state_q, data_exchange_left_event}, 3'h1);
        tl(1, 0);
        tl(3, 0);
        pin(2);
        chk("leave", slave_state_q, 0);
        $display("test states done");
        tl(9, 0);
        chk("mon_quiet", bus_monitor_expired_event, 0);
        for (i = 0; i < 9; i = i + 1) begin
            tl(6, i);
            chk("rate", {wdog_state_q, baud_code_q}, 16 + i);
            tl(7, 0);
            chk("lost", wdog_state_q, 0);
        end
        tl(6, 8'h09);
        chk("rate_bad", {wdog_state_q, baud_code_q}, 6'h08);
        tl(6, 3);
        tl(8, 0);
        chk("monitoring", wdog_state_q, 2);
        tl(9, 0);
        chk("mon_event", bus_monitor_expired_event, 1);
        $display("test watchdog done");
        acc(11'h5FF, 0);
        chk("in_range", ram_range_fault, 0);
        acc(11'h600, 0);
        chk("range", {ram_range_fault, link_layer_halt, ram_fault_event}, 7);
        pin(1);
        chk("fault_clr", ram_range_fault, 0);
        @(posedge clk) host_bus_variant_a <= 1;
        repeat (4) @(posedge clk);
        acc(11'h7FF, 1);
        chk("host_quiet", ram_fault_event, 0);
        acc(11'h600, 0);
        chk("seq_flag", ram_fault_event, 1);
        $display("test ram done");
        pin(0);
        chk("offline", passive_idle_q, 0);
        tl(0, 8'h08);
        chk("off_gc", gc_event, 0);
        tl(1, 0);
        chk("off_prm", slave_state_q, 0);
        pin(1);
        chk("reinit", passive_idle_q, 1);
        $display("test offline done");
        tally_and_finish;
    end
endmodule
bind dpsc_state_ctrl dpsc_state_chk chk_i (.clk, .rst, .ce, .gc_stb, .gc_group_hit, .gc_cmd, .prm_bad_stb,
    .monitor_expired_stb, .acc_stb, .acc_addr, .acc_host, .gc_event, .gc_cmd_q, .data_exchange_left_event,
    .slave_state_q, .passive_idle_q, .bus_monitor_expired_event, .wdog_state_q, .baud_code_q,
    .ram_range_fault, .link_layer_halt, .ram_fault_event);
